// ---- hw/tcc_capture_compare.sv ----
// Capture and compare channels of a 16-bit timer, with an 8-bit register port.
// Assumes a separate counter unit supplies count, tick, TOP and BOTTOM.
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none

// Operation
// RULE1 - A qualified edge copies the 16-bit count into the capture value
// RULE2 - Capture flag rises in the same cycle the capture value loads
// RULE3 - Capture flag with enable requests interrupt; service or write one clears
// RULE4 - Capture low read loads latch with high byte; high read returns latch
// RULE5 - Capture value writable only in capture-TOP modes, high byte first
// RULE6 - Only first instance may capture from comparator output when selected
// RULE7 - Software clears capture flag after switching capture source
// RULE8 - Filter changes level only after four agreeing system-clock samples
// RULE9 - Filter enable bit; four cycles latency; runs on system clock
// RULE10 - Capture triggering disabled in modes where capture value is TOP
// RULE11 - Capture follows the pin level, even when driven by its port
// RULE12 - Each capture overwrites the capture value unconditionally
// RULE13 - Count equal to compare value sets compare flag at next tick
// RULE14 - Compare flag with enable requests interrupt; service or write one clears
// RULE15 - Channel A may define counter TOP
// RULE16 - PWM modes buffer compare value, loaded at TOP or BOTTOM
// RULE17 - Accesses reach buffer or active value; compare reads skip latch
// RULE18 - Compare high write fills latch; low write moves both at once
// RULE19 - Force strobe in non-PWM modes updates output, no flag, no count change
// RULE20 - Count write blocks every compare match at the next tick
// RULE21 - Count written equal to TOP misses that TOP match
// RULE22 - Output mode acts at once; output state survives mode changes
// RULE23 - One high-byte latch serves count, compare and capture values
// RULE24 - Edge select chooses rising or falling capture edge

module tcc_capture_compare #(
   parameter int CHANNELS = 3,          // Compare channels
   parameter bit FIRST_INSTANCE = 1'b1  // Comparator capture allowed
) (
   input wire logic clk_i,                          // System clock, 100 MHz
   input wire logic reset_i,                        // Synchronous reset
   input wire logic ce_i,                           // Clock enable
   input wire logic [4:0] addr_i,                   // Register address
   input wire logic [7:0] wdata_i,                  // Write data
   input wire logic wr_i,                           // Write strobe
   input wire logic rd_i,                           // Read strobe
   output logic [7:0] rdata_o,                      // Read data, cycle after rd_i
   input wire logic capture_pin_i,                  // Capture pin level
   input wire logic comparator_output_i,            // Analog comparator output
   input wire logic timer_tick_i,                   // Timer clock enable pulse
   input wire logic [15:0] timer_count_i,           // Running count
   input wire logic at_top_i,                       // Count at TOP
   input wire logic at_bottom_i,                    // Count at BOTTOM
   input wire logic capture_irq_ack_i,              // Capture interrupt serviced
   input wire logic [CHANNELS-1:0] compare_irq_ack_i, // Compare interrupts serviced
   output logic count_wr_o,                         // Count load pulse
   output logic [15:0] count_wr_data_o,             // Count load value
   output logic [3:0] waveform_mode_o,              // Waveform mode
   output logic [15:0] top_value_o,                 // Variable TOP value
   output logic top_match_o,                        // Count at variable TOP
   output logic [CHANNELS-1:0] compare_match_o,     // Matches taken this tick
   output logic [CHANNELS-1:0] compare_output_o,    // Compare output states
   output logic capture_irq_o,                      // Capture interrupt request
   output logic [CHANNELS-1:0] compare_irq_o        // Compare interrupt requests
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [1:0] pin_sync;
      logic [1:0] cmp_sync;
      logic prev_level;
      logic [3:0] mode;
      logic filter_en;
      logic edge_sel;
      logic source_sel;
      logic [CHANNELS-1:0][1:0] out_mode;
      logic cap_irq_en;
      logic [CHANNELS-1:0] cmp_irq_en;
      logic cap_flag;
      logic [CHANNELS-1:0] cmp_flag;
      logic [15:0] capture;
      logic [7:0] latch;
      logic [CHANNELS-1:0][15:0] active;
      logic [CHANNELS-1:0][15:0] buffer;
      logic [CHANNELS-1:0] pending;
      logic [CHANNELS-1:0] matched;
      logic block;
      logic [CHANNELS-1:0] out_state;
      logic count_wr;
      logic [15:0] count_data;
      logic [7:0] rdata;
   } tcc_state_type;

   tcc_state_type s;
   tcc_state_type next_s;
   logic source_level;
   logic filt_level;
   logic cap_evt;
   logic pwm;
   logic [CHANNELS-1:0] equal;

   if (CHANNELS < 1 || CHANNELS > tcc_pkg::MAX_CHANNELS) begin : g_bad
      $error("tcc_capture_compare supports one to three channels");
   end

   // ***********************************************
   // Capture path
   // ***********************************************
   // Pin level is sampled as seen, so a port-driven level also captures
   assign source_level = (FIRST_INSTANCE && s.source_sel) ? // RULE6
      s.cmp_sync[1] : s.pin_sync[1]; // RULE11

   tcc_noise_filter #(
      .SAMPLES(tcc_pkg::FILTER_SAMPLES)
   ) u_filter (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .enable_i(s.filter_en), // RULE9
      .level_i(source_level),
      .level_o(filt_level)
   );

   // Edge qualifier; source switching can fake an edge, software copes
   always_comb begin
      if (s.edge_sel) begin
         cap_evt = filt_level && !s.prev_level; // RULE24
      end else begin
         cap_evt = !filt_level && s.prev_level;
      end
      if (tcc_pkg::capture_top(s.mode)) begin
         cap_evt = 1'b0; // RULE10
      end
   end

   assign pwm = tcc_pkg::is_pwm(s.mode);

   // One comparator per channel, always running
   for (genvar k = 0; k < CHANNELS; k++) begin : g_cmp
      assign equal[k] = timer_count_i == s.active[k]; // RULE13
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      logic [15:0] target;
      logic [4:0] low_addr;
      next_s = s;
      target = '0;
      low_addr = '0;
      next_s.pin_sync = {s.pin_sync[0], capture_pin_i};
      next_s.cmp_sync = {s.cmp_sync[0], comparator_output_i};
      next_s.prev_level = filt_level;
      next_s.count_wr = 1'b0;
      next_s.rdata = '0;

      // Capture overwrites regardless of an unread stamp
      if (cap_evt) begin
         next_s.capture = timer_count_i; // RULE1 RULE12
      end

      // Timer tick: matches seen last tick become flags and output actions
      if (timer_tick_i) begin
         for (int k = 0; k < CHANNELS; k++) begin
            next_s.matched[k] = s.pending[k];
            if (s.pending[k]) begin
               next_s.out_state[k] = apply_mode(s.out_mode[k], s.out_state[k], pwm);
            end
            next_s.pending[k] = equal[k] && !s.block; // RULE13 RULE20
            if (pwm && (tcc_pkg::load_at_bottom(s.mode) ? at_bottom_i : at_top_i)) begin
               next_s.active[k] = s.buffer[k]; // RULE16
            end
         end
         next_s.block = 1'b0;
      end else begin
         next_s.matched = '0;
      end

      // Register writes
      if (wr_i) begin
         if (addr_i == tcc_pkg::OFS_CTRL) begin
            next_s.mode = wdata_i[tcc_pkg::CTRL_MODE_LSB +: 4];
            next_s.filter_en = wdata_i[tcc_pkg::CTRL_FILTER_BIT]; // RULE9
            next_s.edge_sel = wdata_i[tcc_pkg::CTRL_EDGE_BIT]; // RULE24
            next_s.source_sel = FIRST_INSTANCE && wdata_i[tcc_pkg::CTRL_SOURCE_BIT]; // RULE6
         end else if (addr_i == tcc_pkg::OFS_OUT_MODE) begin
            for (int k = 0; k < CHANNELS; k++) begin
               next_s.out_mode[k] = wdata_i[2*k +: 2]; // RULE22
            end
         end else if (addr_i == tcc_pkg::OFS_FORCE) begin
            for (int k = 0; k < CHANNELS; k++) begin
               if (wdata_i[k] && !pwm) begin
                  next_s.out_state[k] = apply_mode(s.out_mode[k], next_s.out_state[k], 1'b0); // RULE19
               end
            end
         end else if (addr_i == tcc_pkg::OFS_IRQ_EN) begin
            next_s.cap_irq_en = wdata_i[tcc_pkg::FLAG_CAPTURE_BIT];
            next_s.cmp_irq_en = wdata_i[tcc_pkg::FLAG_COMPARE_LSB +: CHANNELS];
         end else if (addr_i == tcc_pkg::OFS_COUNT_LOW) begin
            next_s.count_wr = 1'b1;
            next_s.count_data = {s.latch, wdata_i}; // RULE23
            next_s.block = 1'b1; // RULE20 RULE21
         end else if (addr_i == tcc_pkg::OFS_CAPTURE_LOW) begin
            if (tcc_pkg::capture_top(s.mode) && !cap_evt) begin
               next_s.capture = {s.latch, wdata_i}; // RULE5
            end
         end else if (addr_i == tcc_pkg::OFS_COUNT_HIGH || addr_i == tcc_pkg::OFS_CAPTURE_HIGH) begin
            next_s.latch = wdata_i; // RULE23
         end
         for (int k = 0; k < CHANNELS; k++) begin
            low_addr = tcc_pkg::OFS_COMPARE_BASE + 5'(2 * k);
            if (addr_i == low_addr + 5'h01) begin
               next_s.latch = wdata_i; // RULE18
            end else if (addr_i == low_addr) begin
               if (pwm) begin
                  next_s.buffer[k] = {s.latch, wdata_i}; // RULE17 RULE18
               end else begin
                  next_s.active[k] = {s.latch, wdata_i}; // RULE16 RULE18
               end
            end
         end
      end

      // Register reads, data shown in the next cycle only
      if (rd_i) begin
         if (addr_i == tcc_pkg::OFS_CTRL) begin
            next_s.rdata = {s.filter_en, s.edge_sel, s.source_sel, 1'b0, s.mode};
         end else if (addr_i == tcc_pkg::OFS_OUT_MODE) begin
            next_s.rdata = 8'(s.out_mode);
         end else if (addr_i == tcc_pkg::OFS_IRQ_EN) begin
            next_s.rdata = 8'({s.cmp_irq_en, s.cap_irq_en});
         end else if (addr_i == tcc_pkg::OFS_FLAGS) begin
            next_s.rdata = 8'({s.cmp_flag, s.cap_flag});
         end else if (addr_i == tcc_pkg::OFS_COUNT_LOW) begin
            next_s.rdata = timer_count_i[7:0];
            next_s.latch = timer_count_i[15:8]; // RULE23
         end else if (addr_i == tcc_pkg::OFS_CAPTURE_LOW) begin
            next_s.rdata = s.capture[7:0];
            next_s.latch = s.capture[15:8]; // RULE4
         end else if (addr_i == tcc_pkg::OFS_COUNT_HIGH || addr_i == tcc_pkg::OFS_CAPTURE_HIGH) begin
            next_s.rdata = s.latch; // RULE4
         end else if (addr_i == tcc_pkg::OFS_OUT_STATE) begin
            next_s.rdata = 8'(s.out_state);
         end
         for (int k = 0; k < CHANNELS; k++) begin
            low_addr = tcc_pkg::OFS_COMPARE_BASE + 5'(2 * k);
            target = pwm ? s.buffer[k] : s.active[k];
            if (addr_i == low_addr) begin
               next_s.rdata = target[7:0]; // RULE17
            end else if (addr_i == low_addr + 5'h01) begin
               next_s.rdata = target[15:8]; // RULE17
            end
         end
      end

      // Flags: a set in the clearing cycle wins
      next_s.cap_flag = (s.cap_flag && !capture_irq_ack_i &&
         !(wr_i && addr_i == tcc_pkg::OFS_FLAGS && wdata_i[tcc_pkg::FLAG_CAPTURE_BIT]))
         || cap_evt; // RULE2 RULE3
      for (int k = 0; k < CHANNELS; k++) begin
         next_s.cmp_flag[k] = (s.cmp_flag[k] && !compare_irq_ack_i[k] &&
            !(wr_i && addr_i == tcc_pkg::OFS_FLAGS && wdata_i[tcc_pkg::FLAG_COMPARE_LSB + k]))
            || (timer_tick_i && s.pending[k]); // RULE13 RULE14
      end
   end

   // Output action for one match; toggling only serves non-PWM modes
   function automatic logic apply_mode(input logic [1:0] m, input logic cur, input logic p);
      logic r;
      r = cur;
      if (m == tcc_pkg::COM_TOGGLE) begin
         r = p ? cur : !cur;
      end else if (m == tcc_pkg::COM_CLEAR) begin
         r = 1'b0;
      end else if (m == tcc_pkg::COM_SET) begin
         r = 1'b1;
      end
      return r;
   endfunction

   // Whole state registered at once; output state never reset by a mode change
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s; // RULE22
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign rdata_o = s.rdata;
   assign count_wr_o = s.count_wr;
   assign count_wr_data_o = s.count_data;
   assign waveform_mode_o = s.mode;
   assign top_value_o = tcc_pkg::capture_top(s.mode) ? s.capture : s.active[0]; // RULE15
   // Blocked after a count write, so a count written at TOP runs on
   assign top_match_o = (timer_count_i == top_value_o) && !s.block && // RULE21
      (tcc_pkg::capture_top(s.mode) || tcc_pkg::compare_top(s.mode));
   assign compare_match_o = s.matched;
   assign compare_output_o = s.out_state;
   assign capture_irq_o = s.cap_flag && s.cap_irq_en; // RULE3
   assign compare_irq_o = s.cmp_flag & s.cmp_irq_en; // RULE14

   // ***********************************************
   // Checks
   // ***********************************************
   chk_capture_stamp: assert property ( // RULE1
      @(posedge clk_i) disable iff (reset_i)
      ce_i && cap_evt |=> s.capture == $past(timer_count_i))
      else $error("capture did not store the count");

   chk_capture_flag_same: assert property ( // RULE2
      @(posedge clk_i) disable iff (reset_i)
      $rose(s.cap_flag) |-> $past(cap_evt) && s.capture == $past(timer_count_i))
      else $error("capture flag and capture value out of step");

   chk_capture_ack_clear: assert property ( // RULE3
      @(posedge clk_i) disable iff (reset_i)
      ce_i && capture_irq_ack_i && !cap_evt |=> !s.cap_flag && !capture_irq_o)
      else $error("capture flag not cleared by service");

   chk_latch_on_low: assert property ( // RULE4
      @(posedge clk_i) disable iff (reset_i)
      ce_i && rd_i && addr_i == tcc_pkg::OFS_CAPTURE_LOW
      |=> s.latch == $past(s.capture[15:8]) && rdata_o == $past(s.capture[7:0]))
      else $error("capture low read did not load the latch");

   chk_capture_write_lock: assert property ( // RULE5
      @(posedge clk_i) disable iff (reset_i)
      ce_i && wr_i && addr_i == tcc_pkg::OFS_CAPTURE_LOW
      && !tcc_pkg::capture_top(s.mode) && !cap_evt |=> $stable(s.capture))
      else $error("capture value written outside capture-TOP modes");

   chk_no_top_trigger: assert property ( // RULE10
      @(posedge clk_i) disable iff (reset_i)
      tcc_pkg::capture_top(s.mode) |-> !cap_evt ##1 !$rose(s.cap_flag))
      else $error("capture fired in a capture-TOP mode");

   chk_compare_flag: assert property ( // RULE13
      @(posedge clk_i) disable iff (reset_i)
      ce_i && timer_tick_i && s.pending[0] |=> s.cmp_flag[0] && compare_match_o[0])
      else $error("compare match did not set its flag");

   chk_top_source: assert property ( // RULE15
      @(posedge clk_i) disable iff (reset_i)
      tcc_pkg::compare_top(s.mode) |-> top_value_o == s.active[0])
      else $error("channel A not used as TOP");

   chk_direct_write: assert property ( // RULE18
      @(posedge clk_i) disable iff (reset_i)
      ce_i && wr_i && addr_i == tcc_pkg::OFS_COMPARE_BASE && !pwm
      |=> s.active[0] == {$past(s.latch), $past(wdata_i)})
      else $error("compare low write did not move both bytes");

   chk_force_no_flag: assert property ( // RULE19
      @(posedge clk_i) disable iff (reset_i)
      ce_i && wr_i && addr_i == tcc_pkg::OFS_FORCE && !timer_tick_i && s.cmp_flag == '0
      |=> s.cmp_flag == '0 && !count_wr_o)
      else $error("force strobe set a flag or touched the count");

   chk_count_block: assert property ( // RULE20
      @(posedge clk_i) disable iff (reset_i)
      ce_i && timer_tick_i && s.block |=> s.pending == '0)
      else $error("compare match not blocked after a count write");

endmodule

`default_nettype wire

// ---- hw/tcc_noise_filter.sv ----
// Four-sample agreement filter in front of the capture edge detector.
// Assumes its input is already synchronised to clk_i.
`default_nettype none

module tcc_noise_filter #(
   parameter int SAMPLES = tcc_pkg::FILTER_SAMPLES // Samples that must agree
) (
   input wire logic clk_i,    // System clock
   input wire logic reset_i,  // Synchronous reset, active high
   input wire logic ce_i,     // Clock enable
   input wire logic enable_i, // Filter enable
   input wire logic level_i,  // Synchronised input level
   output logic level_o       // Filtered level
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [SAMPLES-1:0] hist;
      logic level;
   } tcc_filter_type;

   tcc_filter_type s;
   tcc_filter_type next_s;

   if (SAMPLES < 2) begin : g_bad
      $error("tcc_noise_filter needs at least two samples");
   end

   // Shift samples, change level only on full agreement
   always_comb begin
      next_s = s;
      next_s.hist = {s.hist[SAMPLES-2:0], level_i};
      if (next_s.hist == '0 || next_s.hist == '1) begin
         next_s.level = next_s.hist[0]; // RULE8
      end
   end

   // Filter runs on the system clock, never on the timer tick
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s; // RULE9
      end
   end

   // Bypass adds no delay when the filter is off
   assign level_o = enable_i ? s.level : level_i; // RULE9

   chk_filter_settles: assert property ( // RULE8
      @(posedge clk_i) disable iff (reset_i)
      (enable_i && ce_i && level_i)[*4] |=> s.level)
      else $error("filter did not settle after four agreeing samples");

endmodule

`default_nettype wire

// ---- include/tcc_pkg.sv ----
// Shared constants and mode decoding for the timer capture/compare block.
// Assumes an 8-bit register port with a 5-bit byte address.
`default_nettype none

package tcc_pkg;

   // ***********************************************
   // Register offsets
   // ***********************************************
   localparam logic [4:0] OFS_CTRL = 5'h00;         // Mode, filter, edge, source
   localparam logic [4:0] OFS_OUT_MODE = 5'h01;     // Output mode, two bits a channel
   localparam logic [4:0] OFS_FORCE = 5'h02;        // Force strobes, write only
   localparam logic [4:0] OFS_IRQ_EN = 5'h03;       // Interrupt enables
   localparam logic [4:0] OFS_FLAGS = 5'h04;        // Flags, write one to clear
   localparam logic [4:0] OFS_COUNT_LOW = 5'h05;    // Count low byte
   localparam logic [4:0] OFS_COUNT_HIGH = 5'h06;   // Count high byte via latch
   localparam logic [4:0] OFS_CAPTURE_LOW = 5'h07;  // Capture low byte
   localparam logic [4:0] OFS_CAPTURE_HIGH = 5'h08; // Capture high byte via latch
   localparam logic [4:0] OFS_COMPARE_BASE = 5'h09; // Channel k low at base plus 2k
   localparam logic [4:0] OFS_OUT_STATE = 5'h0f;    // Compare output states

   // ***********************************************
   // Field positions and reset values
   // ***********************************************
   localparam int CTRL_MODE_LSB = 0;       // Waveform mode, four bits
   localparam int CTRL_SOURCE_BIT = 5;     // Comparator capture select
   localparam int CTRL_EDGE_BIT = 6;       // One selects rising edge
   localparam int CTRL_FILTER_BIT = 7;     // Capture filter enable
   localparam int FLAG_CAPTURE_BIT = 0;    // Capture flag and enable
   localparam int FLAG_COMPARE_LSB = 1;    // Compare flags and enables
   localparam int MAX_CHANNELS = 3;        // Room in the address map
   localparam int FILTER_SAMPLES = 4;      // Agreeing samples to change level
   localparam logic [15:0] VALUE_RESET = 16'h0000; // Capture and compare reset

   // Output mode encodings
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;

   // ***********************************************
   // Waveform mode classes
   // ***********************************************
   // Normal and clear-on-match modes are the non-PWM ones
   function automatic logic is_pwm(input logic [3:0] m);
      return !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
   endfunction

   // Capture value defines TOP
   function automatic logic capture_top(input logic [3:0] m);
      return m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he;
   endfunction

   // Channel A defines TOP
   function automatic logic compare_top(input logic [3:0] m);
      return m == 4'h4 || m == 4'h9 || m == 4'hb || m == 4'hf;
   endfunction

   // Phase and frequency correct modes reload at BOTTOM
   function automatic logic load_at_bottom(input logic [3:0] m);
      return m == 4'h8 || m == 4'h9;
   endfunction

endpackage

`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the timer capture/compare block.
// Assumes the counter model as the counting side; tick stops while run is low.
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0, comp = 1'b0;
   logic run = 1'b0, ack = 1'b0, e, cwr, tick, at_top, at_bot, cirq;
   logic [3:0] wm;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00, rdata, d;
   logic [15:0] v, w, cwd, cnt, top;
   logic [2:0] mirq, cout;
   logic [1:0] fm [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   int fails = 0, total_checks = 0, cycles = 0;
   always #5 clk_i = ~clk_i;
   tcc_capture_compare dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .capture_pin_i(pin),
      .comparator_output_i(comp), .timer_tick_i(tick), .timer_count_i(cnt),
      .at_top_i(at_top), .at_bottom_i(at_bot), .capture_irq_ack_i(ack),
      .compare_irq_ack_i({2'h0, ack}), .count_wr_o(cwr), .count_wr_data_o(cwd),
      .waveform_mode_o(wm), .top_value_o(top), .top_match_o(), .compare_match_o(),
      .compare_output_o(cout), .capture_irq_o(cirq), .compare_irq_o(mirq));
   tcc_counter_model cm (.clk_i(clk_i), .reset_i(reset_i), .run_i(run), .load_i(cwr),
      .load_data_i(cwd), .top_i(top), .tick_o(tick), .count_o(cnt),
      .at_top_o(at_top), .at_bottom_o(at_bot));
   // Compare and count every result
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe
   task bw(input logic [4:0] a, input logic [7:0] x);
      @(posedge clk_i);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task br(input logic [4:0] a, output logic [7:0] x);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 x = rdata;
   endtask
   // One-cycle interrupt service pulse
   task ak();
      @(posedge clk_i);
      ack <= 1'b1;
      @(posedge clk_i);
      ack <= 1'b0;
   endtask
   task results();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Whole run is a few hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         results();
      end
   end
   initial begin
      void'($urandom(32'hec5fc569));
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      bw(5'h03, 8'h03);
      // Rising pin, falling pin, then comparator source
      for (int i = 0; i < 3; i++) begin
         bw(5'h00, i == 0 ? 8'h40 : i == 1 ? 8'h00 : 8'h60);
         bw(5'h04, 8'h01);
         v = 16'($urandom);
         bw(5'h06, v[15:8]);
         bw(5'h05, v[7:0]);
         repeat (4) @(posedge clk_i);
         if (i < 2) pin <= ~pin;
         else comp <= 1'b1;
         repeat (8) @(posedge clk_i);
         #1 chk(16'(cirq), 16'h0001);
         br(5'h07, d);
         chk(16'(d), 16'(v[7:0]));
         br(5'h08, d);
         chk(16'(d), 16'(v[15:8]));
         if (i == 1) ak();
         else bw(5'h04, 8'h01);
         #1 chk(16'(cirq), 16'h0000);
      end
      $display("capture test done");
      // Filtered pin: short glitch, then a held level
      bw(5'h00, 8'hc0);
      // Let the filter settle low, else the glitch could never trip
      repeat (6) @(posedge clk_i);
      pin <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin <= 1'b0;
      repeat (12) @(posedge clk_i);
      #1 chk(16'(cirq), 16'h0000);
      pin <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1 chk(16'(cirq), 16'h0000);
      repeat (4) @(posedge clk_i);
      #1 chk(16'(cirq), 16'h0001);
      $display("filter test done");
      // Count written equal to compare value, then two below it
      bw(5'h00, 8'h00);
      v = 16'($urandom);
      bw(5'h0a, v[15:8]);
      bw(5'h09, v[7:0]);
      bw(5'h06, v[15:8]);
      bw(5'h05, v[7:0]);
      bw(5'h04, 8'h02);
      run <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1 chk(16'(mirq[0]), 16'h0000);
      w = v - 16'h0002;
      bw(5'h06, w[15:8]);
      bw(5'h05, w[7:0]);
      repeat (12) @(posedge clk_i);
      #1 chk(16'(mirq[0]), 16'h0001);
      run <= 1'b0;
      br(5'h04, d);
      chk(16'(d[1]), 16'h0001);
      ak();
      #1 chk(16'(mirq[0]), 16'h0000);
      $display("compare test done");
      // PWM buffers channel A; capture-TOP mode locks out capture
      bw(5'h00, 8'h0f);
      bw(5'h0a, w[7:0]);
      bw(5'h09, w[15:8]);
      #1 chk(top, v);
      br(5'h09, d);
      chk(16'(d), 16'(w[15:8]));
      bw(5'h00, 8'h0c);
      w = 16'($urandom);
      bw(5'h08, w[15:8]);
      bw(5'h07, w[7:0]);
      pin <= ~pin;
      repeat (8) @(posedge clk_i);
      #1 chk(top, w);
      chk(16'(cirq), 16'h0000);
      chk(16'(wm), 16'h000c);
      $display("mode test done");
      // Force with set, clear and two toggles
      bw(5'h04, 8'h03);
      e = 1'b0;
      foreach (fm[k]) begin
         bw(5'h01, {6'h00, fm[k]});
         bw(5'h02, 8'h01);
         e = fm[k] == 2'h3 ? 1'b1 : fm[k] == 2'h2 ? 1'b0 : ~e;
         #1 chk(16'(cout[0]), 16'(e));
      end
      br(5'h04, d);
      chk(16'(d), 16'h0000);
      $display("force test done");
      results();
   end
endmodule

`default_nettype wire

// ---- verif/tcc_counter_model.sv ----
// Counting side beside the capture/compare block: count, tick, TOP, BOTTOM.
// Assumes one clock; ticks every second cycle while run_i is high.
`default_nettype none

module tcc_counter_model (
   input wire logic clk_i,              // System clock
   input wire logic reset_i,            // Synchronous reset
   input wire logic run_i,              // Let the timer clock run
   input wire logic load_i,             // Count load pulse
   input wire logic [15:0] load_data_i, // Count load value
   input wire logic [15:0] top_i,       // Variable TOP
   output logic tick_o,                 // Timer clock enable
   output logic [15:0] count_o,         // Running count
   output logic at_top_o,               // Count at TOP
   output logic at_bottom_o             // Count at BOTTOM
);
   timeunit 1ns;
   timeprecision 1ps;
   // A CPU load wins over counting, so a written value is never skipped
   always @(posedge clk_i) begin
      if (reset_i) begin
         tick_o <= 1'b0;
         count_o <= 16'h0000;
      end else begin
         tick_o <= run_i & ~tick_o;
         if (load_i) count_o <= load_data_i;
         else if (tick_o) count_o <= count_o + 16'h0001;
      end
   end
   assign at_top_o = count_o == top_i;
   assign at_bottom_o = count_o == 16'h0000;
endmodule

`default_nettype wire
